// >>> common/dea_buf_if.sv
// Interface: page buffer access between controller and buffer
`timescale 1ns/100ps
interface dea_buf_if;
	logic load;
	logic clear;
	logic [3:0] idx;
	logic [7:0] wdata;
	logic [7:0] rdata;
	modport ctrl (output load, output clear, output idx, output wdata, input rdata);
	modport buf_side (input load, input clear, input idx, input wdata, output rdata);
endinterface : dea_buf_if

// >>> common/dea_pkg.sv
// Package: constants and types for the data EEPROM access control block
package dea_pkg;
	// =====================================================================
	// Register map (sector:offset of the indirect pointer)
	localparam logic [7:0] NVM_CONTROL_OFS = 8'h40;
	localparam logic [7:0] NVM_CONTROL_SEC = 8'h01;
	localparam logic [7:0] NVM_ADDRESS_OFS = 8'h41;
	localparam logic [7:0] NVM_DATA_OFS = 8'h42;
	localparam logic [7:0] NVM_CONTROL_RST = 8'h00;
	// =====================================================================
	// Control bit positions
	localparam int RD_START_POS = 0;
	localparam int RD_EN_POS = 1;
	localparam int WR_START_POS = 2;
	localparam int WR_EN_POS = 3;
	localparam int PAGE_MODE_POS = 4;
	localparam int ER_START_POS = 5;
	localparam int ER_EN_POS = 6;
	// =====================================================================
	// Geometry and timing
	localparam int PAGE_BYTES = 16;
	localparam int ADDR_W = 7;
	localparam int LOW_W = 4;
	localparam logic [3:0] PAGE_END = 4'hF;
	localparam int CLK_MHZ = 40;
	localparam int READ_NS = 100;
	localparam int READ_CYC = (READ_NS * CLK_MHZ + 999) / 1000;
	localparam int PROG_US = 2000;
	localparam int PROG_CYC = PROG_US * CLK_MHZ;

	typedef enum logic [3:0] {
		DEA_IDLE = 4'b0001,
		DEA_READ = 4'b0010,
		DEA_ERASE = 4'b0100,
		DEA_WRITE = 4'b1000
	} dea_state_t;
endpackage : dea_pkg

// >>> verif/dea_ctrl_sva.sv
// Checker: port assertions for the data EEPROM access controller
`timescale 1ns/100ps
module dea_ctrl_sva #(
	parameter int PROG_CYCLES = 20,
	parameter int READ_CYCLES = 4
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic arst_n,
	// Processor side
	input wire logic [7:0] pointer_high_byte,
	input wire logic [7:0] mem_addr,
	input wire logic mem_indirect,
	input wire logic mem_wr,
	input wire logic [7:0] mem_wdata,
	input wire logic [7:0] mem_rdata,
	input wire logic power_down,
	// Array and events
	input wire logic arr_write,
	input wire logic arr_erase,
	input wire logic cycle_done,
	input wire logic cycle_failed
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!arst_n);
	wire cw = mem_wr && mem_indirect && pointer_high_byte == 8'h01 && mem_addr == 8'h40;
	wire rc = mem_indirect && pointer_high_byte == 8'h01 && mem_addr == 8'h40;
	wire busy = arr_write || arr_erase;
	logic [31:0] run_q;
	// =====================================================================
	// Cycle length counter
	always_ff @(posedge mclk or negedge arst_n)
		if (!arst_n)
			run_q <= '0;
		else
			run_q <= busy ? run_q + 32'd1 : '0;
	// =====================================================================
	// Assertions
	done_pulse_a: assert property (cycle_done |=> !cycle_done)
		else $error("done pulse longer than one cycle");
	fail_pulse_a: assert property (cycle_failed |=> !cycle_failed)
		else $error("fail pulse longer than one cycle");
	single_event_a: assert property (!(cycle_done && cycle_failed))
		else $error("done and fail together");
	no_enable_a: assert property (cw && mem_wdata == 8'h04 && !busy |=> !arr_write)
		else $error("write began without enable");
	abort_fail_a: assert property (power_down && busy |-> ##[0:2] cycle_failed)
		else $error("power down did not fail the cycle");
	prog_hold_a: assert property ($rose(arr_write) ##0 !power_down [*8] |-> arr_write)
		else $error("write cycle ended early");
	prog_bound_a: assert property (busy |-> run_q <= PROG_CYCLES + 1)
		else $error("cycle ran too long");
	end_event_a: assert property ($fell(arr_write) |-> ##[0:2] (cycle_done || cycle_failed))
		else $error("write end without event");
	zero_ctrl_a: assert property (cw && mem_wdata == 8'h00 && !busy |=> !rc || mem_rdata == 8'h00)
		else $error("control not cleared by zero write");
	sector_a: assert property (mem_wr && mem_indirect && pointer_high_byte == 8'h00 && !busy
		|=> !busy)
		else $error("control reached from wrong sector");
endmodule : dea_ctrl_sva

bind dea_ctrl dea_ctrl_sva #(.PROG_CYCLES(PROG_CYCLES), .READ_CYCLES(READ_CYCLES)) dea_ctrl_sva_i (
	.mclk, .arst_n, .pointer_high_byte, .mem_addr, .mem_indirect, .mem_wr, .mem_wdata,
	.mem_rdata, .power_down, .arr_write, .arr_erase, .cycle_done, .cycle_failed);

// >>> verif/testbench.sv
// Testbench: directed scenarios for the data EEPROM access controller
`timescale 1ns/100ps
module testbench;
	logic mclk = 1'b0;
	logic arst_n = 1'b0;
	logic [7:0] hi = 8'h01;
	logic [7:0] addr = 8'h00;
	logic ind = 1'b0;
	logic wr_s = 1'b0;
	logic [7:0] wd = 8'h00;
	logic pd = 1'b0;
	logic [7:0] rdat, awd, v;
	logic [6:0] aa;
	logic aw, ae, dn, fl;
	logic [7:0] n_done = 8'h00;
	logic [7:0] n_fail = 8'h00;
	int error_cnt = 0;
	int checked = 0;
	int cyc = 0;
	always #12.5 mclk = ~mclk;
	// Event pulses counted at the edge after launch; a long pulse counts twice
	always @(posedge mclk)
	begin
		if (dn === 1'b1)
			n_done = n_done + 8'h01;
		if (fl === 1'b1)
			n_fail = n_fail + 8'h01;
	end
	dea_ctrl #(.PROG_CYCLES(20)) dea_ctrl_i (.mclk(mclk), .arst_n(arst_n),
		.pointer_high_byte(hi), .mem_addr(addr), .mem_indirect(ind), .mem_wr(wr_s),
		.mem_wdata(wd), .mem_rdata(rdat), .power_down(pd), .arr_addr(aa), .arr_wdata(awd),
		.arr_write(aw), .arr_erase(ae), .arr_rdata({1'b0, aa} ^ 8'h5A), .cycle_done(dn),
		.cycle_failed(fl));
	// =====================================================================
	// Shared tasks
	task chk(input string n, input logic [7:0] s, input logic [7:0] e);
		checked++;
		if (s !== e)
		begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		#1;
		{addr, ind, wd, wr_s} = {a, a == 8'h40, d, 1'b1};
		@(posedge mclk);
		#1;
		wr_s = 1'b0;
	endtask : wr
	task rd(input logic [7:0] a);
		@(posedge mclk);
		#1;
		{addr, ind} = {a, a == 8'h40};
		#5;
		v = rdat;
	endtask : rd
	// Bounded poll of a self-clearing start bit
	task wt(input int b);
		int n;
		n = 0;
		rd(8'h40);
		while (v[b] !== 1'b0 && n < 200)
		begin
			rd(8'h40);
			n++;
		end
		chk("start bit", {7'h00, v[b]}, 8'h00);
	endtask : wt
	task print_verdict;
		$display("checks %0d errors %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : print_verdict
	// =====================================================================
	// Scenarios
	task t_byte_write;
		wr(8'h41, 8'h25);
		wr(8'h42, 8'hA5);
		wr(8'h40, 8'h08);
		wr(8'h40, 8'h0C);
		@(posedge mclk);
		#1;
		chk("arr_write", {7'h00, aw}, 8'h01);
		chk("arr_erase", {7'h00, ae}, 8'h01);
		chk("arr_wdata", awd, 8'hA5);
		chk("arr_addr", {1'b0, aa}, 8'h25);
		wt(2);
		rd(8'h40);
		chk("ctrl after write", v, 8'h00);
		chk("done pulses", n_done, 8'h01);
		rd(8'h42);
		chk("data read back", v, 8'hA5);
	endtask : t_byte_write
	task t_refuse;
		wr(8'h40, 8'h04);
		rd(8'h40);
		chk("start without enable", v, 8'h00);
		wr(8'h40, 8'h08);
		wr(8'h40, 8'h18);
		wr(8'h40, 8'h1C);
		chk("late start", {7'h00, aw}, 8'h00);
		wr(8'h40, 8'h00);
		hi = 8'h00;
		wr(8'h40, 8'h48);
		hi = 8'h01;
		rd(8'h40);
		chk("sector 0 access", v, 8'h00);
	endtask : t_refuse
	task t_read;
		wr(8'h41, 8'h13);
		wr(8'h40, 8'h02);
		wr(8'h40, 8'h03);
		rd(8'h40);
		chk("read running", v, 8'h03);
		wt(0);
		rd(8'h42);
		chk("read byte", v, 8'h13 ^ 8'h5A);
		wr(8'h40, 8'h00);
		rd(8'h40);
		chk("read off", v, 8'h00);
	endtask : t_read
	task t_page_read;
		wr(8'h40, 8'h12);
		wr(8'h41, 8'h1E);
		for (int i = 0; i < 3; i++)
		begin
			wr(8'h40, 8'h13);
			wt(0);
			rd(8'h42);
			chk("page byte", v, (i == 0 ? 8'h1E : 8'h1F) ^ 8'h5A);
		end
		wr(8'h40, 8'h00);
	endtask : t_page_read
	task t_page_write;
		wr(8'h40, 8'h10);
		wr(8'h41, 8'h30);
		repeat (16) wr(8'h42, 8'hC3);
		// Seventeenth byte differs so a stray load would show
		wr(8'h42, 8'h3C);
		rd(8'h41);
		chk("page address stop", v, 8'h3F);
		wr(8'h40, 8'h18);
		wr(8'h40, 8'h1C);
		chk("page write", {7'h00, aw}, 8'h01);
		chk("page last byte", awd, 8'hC3);
		chk("page base", {1'b0, aa}, 8'h30);
		wt(2);
		rd(8'h40);
		chk("enable cleared", v & 8'h0C, 8'h00);
		chk("done pulses", n_done, 8'h02);
		wr(8'h40, 8'h00);
	endtask : t_page_write
	task t_erase;
		wr(8'h40, 8'h40);
		wr(8'h40, 8'h60);
		chk("erase only", {6'h00, aw, ae}, 8'h01);
		wt(5);
		wr(8'h40, 8'h20);
		chk("erase without enable", {7'h00, ae}, 8'h00);
		chk("done pulses", n_done, 8'h03);
		wr(8'h40, 8'h40);
		wr(8'h40, 8'h60);
		pd = 1'b1;
		@(posedge mclk);
		#1;
		pd = 1'b0;
		rd(8'h40);
		chk("abort start bit", v & 8'h20, 8'h00);
		chk("fail pulses", n_fail, 8'h01);
		chk("no done on abort", n_done, 8'h03);
	endtask : t_erase
	// =====================================================================
	// Sequence and hang limit
	always @(posedge mclk)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			error_cnt++;
			print_verdict;
		end
	end
	initial
	begin
		repeat (12) @(posedge mclk);
		#1;
		arst_n = 1'b1;
		rd(8'h40);
		chk("ctrl reset", v, 8'h00);
		t_byte_write;
		t_refuse;
		t_read;
		t_page_read;
		t_page_write;
		t_erase;
		print_verdict;
	end
endmodule : testbench

// >>> verilog/dea_ctrl.sv
// Module: data EEPROM access controller with indirect control register
`timescale 1ns/100ps
// Overview of operation
// RL1: Software keeps write enable low when not writing.
// RL2: Control register reachable only while pointer high byte selects sector 1; code checks the high byte on indirect access only.
// RL3: Software may read back written data to verify it.
// RL4: Write start counts only in the access right after write enable set; code accepts it in the next control write, other accesses may come between.
// RL5: Software masks global interrupt around enable/start pairs.
// RL6: Power-down during a cycle makes that cycle fail.
// RL7: Control register sits at low pointer 040H, high pointer 01H.
// RL8: Control bit 4 selects byte (0) or page (1) operations.
// RL9: Bit 1 enables reading; bit 0 starts read, cleared when done.
// RL10: Bit 3 enables writing; bit 2 starts write, cleared when done.
// RL11: Bit 6 enables erasing; bit 5 starts erase, cleared when done.
// RL12: A page transfer handles at most 16 bytes.
// RL13: Page erase loads bytes for extent only; their values are ignored.
// RL14: In page read each start fetches next byte into data register.
// RL15: Writing zero to control register ends the read session.
// RL16: Write start without write enable set starts nothing.
// RL17: Page address low nibble increments, stops at 0FH, extra writes ignored.
// RL18: Page buffer cleared at reset and on write enable falling edge.
// RL19: Byte write erases first; write enable cleared when write ends.
// RL20: One cycle at a time; enable/start pairs are independent per type.
module dea_ctrl #(
	parameter int PROG_CYCLES = dea_pkg::PROG_CYC,
	parameter int READ_CYCLES = dea_pkg::READ_CYC
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic arst_n,
	// Processor data memory access
	input wire logic [7:0] pointer_high_byte,
	input wire logic [7:0] mem_addr,
	input wire logic mem_indirect,
	input wire logic mem_wr,
	input wire logic [7:0] mem_wdata,
	output logic [7:0] mem_rdata,
	// Power-down request from core
	input wire logic power_down,
	// Array port
	output logic [6:0] arr_addr,
	output logic [7:0] arr_wdata,
	output logic arr_write,
	output logic arr_erase,
	input wire logic [7:0] arr_rdata,
	// Cycle end event
	output logic cycle_done,
	output logic cycle_failed
);
	typedef struct packed {
		dea_pkg::dea_state_t st;
		logic [7:0] ctrl;
		logic [6:0] addr;
		logic [7:0] data;
		logic [31:0] cnt;
		logic [3:0] widx;
		logic write_enable_bit_armed;
		logic done;
		logic failed;
	} dea_st_t;

	dea_st_t s_q;
	dea_st_t s_d;
	dea_buf_if bi ();

	initial
	begin
		if (PROG_CYCLES < 1 || READ_CYCLES < 1)
			$error("dea_ctrl: cycle counts must be at least one");
	end

	dea_page_buf #(.DEPTH(dea_pkg::PAGE_BYTES)) u_buf (
		.mclk(mclk),
		.arst_n(arst_n),
		.bi(bi)
	);

	function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs, input logic ind,
		input logic [7:0] hi);
		hit = (a == ofs) && (!ind || hi == dea_pkg::NVM_CONTROL_SEC);
	endfunction : hit

	logic sel_ctl;
	logic sel_adr;
	logic sel_dat;
	logic page;
	assign sel_ctl = hit(mem_addr, dea_pkg::NVM_CONTROL_OFS, mem_indirect,
		pointer_high_byte); // [RL2] [RL7]
	assign sel_adr = hit(mem_addr, dea_pkg::NVM_ADDRESS_OFS, 1'b0, 8'h00);
	assign sel_dat = hit(mem_addr, dea_pkg::NVM_DATA_OFS, 1'b0, 8'h00);
	assign page = s_q.ctrl[dea_pkg::PAGE_MODE_POS]; // [RL8]

	always_comb
	begin
		logic [7:0] nc;
		logic wr_en_fall;
		nc = 8'h00;
		wr_en_fall = 1'b0;
		s_d = s_q;
		s_d.done = 1'b0;
		s_d.failed = 1'b0;
		bi.load = 1'b0;
		bi.clear = 1'b0;
		bi.idx = s_q.widx;
		bi.wdata = s_q.data;
		// ==============================================================
		// Register writes
		if (mem_wr && sel_ctl)
		begin
			nc = mem_wdata & 8'h7F;
			// Start bits are only set by software, hardware clears them
			if (s_q.st != dea_pkg::DEA_IDLE)
				nc = (nc & 8'hDA) | (s_q.ctrl & 8'h25); // [RL20]
			wr_en_fall = s_q.ctrl[dea_pkg::WR_EN_POS] && !nc[dea_pkg::WR_EN_POS];
			// Armed until the next control write, so slow cores can still pair them
			s_d.write_enable_bit_armed = !s_q.ctrl[dea_pkg::WR_EN_POS] && nc[dea_pkg::WR_EN_POS];
			// Start without a just-set enable is dropped
			if (s_q.st == dea_pkg::DEA_IDLE &&
				(!s_q.write_enable_bit_armed || !nc[dea_pkg::WR_EN_POS]))
				nc[dea_pkg::WR_START_POS] = 1'b0; // [RL4] [RL16]
			if (!nc[dea_pkg::RD_EN_POS] && s_q.st == dea_pkg::DEA_IDLE)
				nc[dea_pkg::RD_START_POS] = 1'b0; // [RL9] [RL15]
			if (!nc[dea_pkg::ER_EN_POS] && s_q.st == dea_pkg::DEA_IDLE)
				nc[dea_pkg::ER_START_POS] = 1'b0; // [RL11]
			s_d.ctrl = nc;
		end
		if (mem_wr && sel_adr && s_q.st == dea_pkg::DEA_IDLE)
		begin
			s_d.addr = mem_wdata[6:0];
			s_d.widx = 4'h0;
		end
		if (mem_wr && sel_dat && s_q.st == dea_pkg::DEA_IDLE)
		begin
			s_d.data = mem_wdata;
			if (page)
			begin
				// Past the page end the byte is dropped
				if (s_q.widx != dea_pkg::PAGE_END)
				begin
					bi.load = 1'b1;
					bi.idx = s_q.addr[3:0];
					bi.wdata = mem_wdata;
					if (s_q.addr[3:0] != dea_pkg::PAGE_END)
						s_d.addr = {s_q.addr[6:4], s_q.addr[3:0] + 4'h1}; // [RL17] [RL12]
					else
						s_d.widx = dea_pkg::PAGE_END; // [RL17]
				end
			end
		end
		if (wr_en_fall)
			bi.clear = 1'b1; // [RL18]
		// ==============================================================
		// Cycle sequencer
		unique case (s_q.st)
			dea_pkg::DEA_IDLE:
			begin
				s_d.cnt = 32'h0;
				if (s_d.ctrl[dea_pkg::RD_START_POS] && s_d.ctrl[dea_pkg::RD_EN_POS])
					s_d.st = dea_pkg::DEA_READ; // [RL20]
				else if (s_d.ctrl[dea_pkg::ER_START_POS] && s_d.ctrl[dea_pkg::ER_EN_POS])
					s_d.st = dea_pkg::DEA_ERASE;
				else if (s_d.ctrl[dea_pkg::WR_START_POS])
					s_d.st = dea_pkg::DEA_WRITE;
			end
			default:
			begin
				s_d.cnt = s_q.cnt + 32'h1;
				if (power_down)
				begin
					s_d.st = dea_pkg::DEA_IDLE; // [RL6]
					s_d.ctrl = s_d.ctrl & 8'hDA;
					s_d.failed = 1'b1;
				end
				else if (s_q.st == dea_pkg::DEA_READ &&
					s_q.cnt == 32'(READ_CYCLES - 1))
				begin
					s_d.data = arr_rdata; // [RL14]
					s_d.ctrl[dea_pkg::RD_START_POS] = 1'b0; // [RL9]
					s_d.st = dea_pkg::DEA_IDLE;
					if (page)
						s_d.addr = {s_q.addr[6:4], s_q.addr[3:0] +
							((s_q.addr[3:0] != dea_pkg::PAGE_END) ? 4'h1 : 4'h0)};
				end
				else if (s_q.st != dea_pkg::DEA_READ && s_q.cnt == 32'(PROG_CYCLES - 1))
				begin
					s_d.st = dea_pkg::DEA_IDLE;
					s_d.done = 1'b1;
					if (s_q.st == dea_pkg::DEA_ERASE)
						s_d.ctrl[dea_pkg::ER_START_POS] = 1'b0; // [RL11]
					else
					begin
						s_d.ctrl[dea_pkg::WR_START_POS] = 1'b0; // [RL10]
						s_d.ctrl[dea_pkg::WR_EN_POS] = 1'b0; // [RL19]
						bi.clear = 1'b1; // [RL18]
					end
				end
			end
		endcase
	end

	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			s_q <= '0;
			s_q.st <= dea_pkg::DEA_IDLE;
			s_q.ctrl <= dea_pkg::NVM_CONTROL_RST; // [RL18]
		end
		else
			s_q <= s_d;
	end

	// ==================================================================
	// Outputs
	always_comb
	begin
		mem_rdata = 8'h00;
		if (sel_ctl)
			mem_rdata = s_q.ctrl;
		else if (sel_adr)
			mem_rdata = {1'b0, s_q.addr};
		else if (sel_dat)
			mem_rdata = s_q.data;
	end

	// Page erase and write start at the page base; page read walks the address
	assign arr_addr = (page && s_q.st != dea_pkg::DEA_READ) ?
		{s_q.addr[6:4], 4'h0} : s_q.addr; // [RL14]
	// Byte write carries its own erase; page erase ignores buffer values
	assign arr_wdata = page ? bi.rdata : s_q.data; // [RL13]
	assign arr_write = s_q.st == dea_pkg::DEA_WRITE;
	assign arr_erase = s_q.st == dea_pkg::DEA_ERASE ||
		(s_q.st == dea_pkg::DEA_WRITE && !page); // [RL19]
	assign cycle_done = s_q.done;
	assign cycle_failed = s_q.failed;
endmodule : dea_ctrl

// >>> verilog/dea_page_buf.sv
// Module: 16-byte page buffer held in flip-flops
`timescale 1ns/100ps
module dea_page_buf #(
	parameter int DEPTH = dea_pkg::PAGE_BYTES
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic arst_n,
	// Controller side
	dea_buf_if.buf_side bi
);
	typedef struct packed {
		logic [DEPTH-1:0][7:0] mem;
	} dea_buf_st_t;
	dea_buf_st_t s_q;
	dea_buf_st_t s_d;

	initial
	begin
		if (DEPTH != 16)
			$error("dea_page_buf: DEPTH must be 16");
	end

	always_comb
	begin
		s_d = s_q;
		if (bi.clear)
			s_d.mem = '0;
		else if (bi.load)
			s_d.mem[bi.idx] = bi.wdata;
	end

	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	assign bi.rdata = s_q.mem[bi.idx];
endmodule : dea_page_buf
